// ---- comparator_output_control_defines.vh ----
// Constants for the comparator output control block
`ifndef COMPARATOR_OUTPUT_CONTROL_DEFINES_VH
`define COMPARATOR_OUTPUT_CONTROL_DEFINES_VH

`define ADDR_W              8
`define OFF_CONTROL_FIRST   8'h00
`define OFF_CONTROL_SECOND  8'h04
`define OFF_SHARED_RESULT   8'h08
`define OFF_PORT_PIN        8'h0C
`define OFF_INT_STATUS      8'h10
`define OFF_INT_MASK        8'h14

`define BIT_ENABLE          7
`define BIT_RESULT          6
`define BIT_PIN_OE          5
`define BIT_INVERT          4
`define BIT_SPEED           2

`define BIT_EDGE_RISE       7
`define BIT_EDGE_FALL       6

`define BIT_MIRROR          0

`define BIT_DIRECTION       0
`define BIT_LATCH           1

`define BIT_EDGE_FLAG       0

`define RST_SPEED           1'b1
`define RST_DIRECTION       1'b1
`define RST_ZERO            1'b0

`define INSTR_DIV_DEFAULT   4

`endif

// ---- level_sync.v ----
// Two flip-flop synchroniser for one level
`default_nettype none
module level_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output reg  sync_out
);

    reg stage_one;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= 1'b0;
            sync_out  <= 1'b0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule
`default_nettype wire

// ---- comparator_output_control.v ----
// Comparator control, result latching, pin override and APB registers
`include "comparator_output_control_defines.vh"
`default_nettype none
module comparator_output_control #(
    parameter INSTR_DIV = `INSTR_DIV_DEFAULT
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        core_raw_result,
    output reg         core_power_on,
    output reg         core_speed_normal,
    output reg         pin_out,
    output reg         pin_oe,
    output reg         irq
);

    // Control and status bits
    reg        comparator_enable_bit;
    reg        pin_output_enable;
    reg        output_invert_bit;
    reg        speed_power_select;
    reg        edge_rise_enable;
    reg        edge_fall_enable;
    reg        pin_direction_bit;
    reg        port_data_latch;
    reg        int_mask;
    reg        int_status;

    // Result path
    wire       raw_synced;
    reg        comparator_result_status;
    reg  [7:0] div_count;
    reg        instr_tick;

    // Bus decode
    wire       setup_phase;
    wire       access_done;
    wire       wr_done;
    wire       rd_done;
    wire [7:0] addr_lo;
    reg  [31:0] next_rdata;
    reg        next_err;

    wire       next_result;
    wire       rise_event;
    wire       fall_event;
    wire       edge_event;
    wire       status_read;
    wire       pin_data;

    // Offset decode used by the error flag only; the read mux decodes with its own case
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `OFF_CONTROL_FIRST)  ||
                        (a == `OFF_CONTROL_SECOND) ||
                        (a == `OFF_SHARED_RESULT)  ||
                        (a == `OFF_PORT_PIN)       ||
                        (a == `OFF_INT_STATUS)     ||
                        (a == `OFF_INT_MASK);
        end
    endfunction

    level_sync u_result_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (core_raw_result),
        .sync_out (raw_synced)
    );

    assign addr_lo     = paddr[7:0];
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done     = access_done & pwrite & ~pslverr;
    assign rd_done     = access_done & ~pwrite & ~pslverr;

    // Instruction cycle enable; divider keeps the single clock domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count  <= 8'h00;
            instr_tick <= 1'b0;
        end else if (div_count == INSTR_DIV[7:0] - 8'h01) begin
            div_count  <= 8'h00;
            instr_tick <= 1'b1;
        end else begin
            div_count  <= div_count + 8'h01;
            instr_tick <= 1'b0;
        end
    end

    // Polarity applied as XOR, same as swapping the inputs
    assign next_result = comparator_enable_bit &
                         (raw_synced ^ output_invert_bit);

    // Latched once per instruction cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_result_status <= `RST_ZERO;
        end else if (instr_tick) begin
            comparator_result_status <= next_result;
        end
    end

    assign rise_event = instr_tick & next_result &
                        ~comparator_result_status & edge_rise_enable;
    assign fall_event = instr_tick & ~next_result &
                        comparator_result_status & edge_fall_enable;
    assign edge_event = rise_event | fall_event;

    assign status_read = rd_done & (addr_lo == `OFF_INT_STATUS);

    // Register writes land at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_enable_bit <= `RST_ZERO;
            pin_output_enable     <= `RST_ZERO;
            output_invert_bit     <= `RST_ZERO;
            speed_power_select    <= `RST_SPEED;
            edge_rise_enable      <= `RST_ZERO;
            edge_fall_enable      <= `RST_ZERO;
            pin_direction_bit     <= `RST_DIRECTION;
            port_data_latch       <= `RST_ZERO;
            int_mask              <= `RST_ZERO;
        end else if (wr_done) begin
            case (addr_lo)
                `OFF_CONTROL_FIRST: begin
                    comparator_enable_bit <= pwdata[`BIT_ENABLE];
                    pin_output_enable     <= pwdata[`BIT_PIN_OE];
                    output_invert_bit     <= pwdata[`BIT_INVERT];
                    speed_power_select    <= pwdata[`BIT_SPEED];
                end
                `OFF_CONTROL_SECOND: begin
                    edge_rise_enable <= pwdata[`BIT_EDGE_RISE];
                    edge_fall_enable <= pwdata[`BIT_EDGE_FALL];
                end
                `OFF_PORT_PIN: begin
                    pin_direction_bit <= pwdata[`BIT_DIRECTION];
                    port_data_latch   <= pwdata[`BIT_LATCH];
                end
                `OFF_INT_MASK: begin
                    int_mask <= pwdata[`BIT_EDGE_FLAG];
                end
                default: begin
                    int_mask <= int_mask;
                end
            endcase
        end
    end

    // Sticky flag; a new edge beats the clearing read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= `RST_ZERO;
        end else if (edge_event) begin
            int_status <= 1'b1;
        end else if (status_read) begin
            int_status <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (int_status | edge_event) & int_mask &
                   ~(status_read & ~edge_event);
        end
    end

    // Read data
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = ~is_mapped(addr_lo);
        case (addr_lo)
            `OFF_CONTROL_FIRST: begin
                next_rdata[`BIT_ENABLE] = comparator_enable_bit;
                next_rdata[`BIT_RESULT] = comparator_result_status;
                next_rdata[`BIT_PIN_OE] = pin_output_enable;
                next_rdata[`BIT_INVERT] = output_invert_bit;
                next_rdata[`BIT_SPEED]  = speed_power_select;
            end
            `OFF_CONTROL_SECOND: begin
                next_rdata[`BIT_EDGE_RISE] = edge_rise_enable;
                next_rdata[`BIT_EDGE_FALL] = edge_fall_enable;
            end
            `OFF_SHARED_RESULT: begin
                next_rdata[`BIT_MIRROR] = comparator_result_status;
            end
            `OFF_PORT_PIN: begin
                next_rdata[`BIT_DIRECTION] = pin_direction_bit;
                next_rdata[`BIT_LATCH]     = port_data_latch;
            end
            `OFF_INT_STATUS: begin
                next_rdata[`BIT_EDGE_FLAG] = int_status;
            end
            `OFF_INT_MASK: begin
                next_rdata[`BIT_EDGE_FLAG] = int_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // No wait state; registered from the setup phase so read data and error come from flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= next_err;
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // Analog core controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_power_on     <= 1'b0;
            core_speed_normal <= `RST_SPEED;
        end else begin
            core_power_on     <= comparator_enable_bit;
            core_speed_normal <= speed_power_select;
        end
    end

    // Pin drive follows the direction bit only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= ~pin_direction_bit;
        end
    end

    // Pin skips the instruction-cycle latch; only the synchroniser and the
    // output flop stand between it and the core
    assign pin_data = pin_output_enable ? next_result :
                      port_data_latch;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= `RST_ZERO;
        end else begin
            pin_out <= pin_data;
        end
    end

endmodule
`default_nettype wire

// ---- comparator_output_control_props.sv ----
// Port checker for the comparator output control block
`default_nettype none
module comparator_output_control_props (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        core_raw_result,
    input  wire logic        core_power_on,
    input  wire logic        core_speed_normal,
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    input  wire logic        irq
);
    logic       en, oe, inv, lat, dir, spd, msk, en_q, dir_q, spd_q, msk_q;
    wire  [7:0] a      = paddr[7:0];
    wire        wr     = psel && penable && pready && pwrite;
    wire        mapped = (a[1:0] == 2'h0) && (a[7:2] < 6'h06);
    // Shadow of the control bits, so pin checks need no internal probes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en, oe, inv, lat, msk} <= 5'h00;
            {dir, spd} <= 2'h3;
            {en_q, dir_q, spd_q, msk_q} <= 4'h6;
        end else begin
            {en_q, dir_q, spd_q, msk_q} <= {en, dir, spd, msk};
            if (wr && a == 8'h00)
                {en, oe, inv, spd} <= {pwdata[7], pwdata[5:4], pwdata[2]};
            if (wr && a == 8'h0C)
                {lat, dir} <= pwdata[1:0];
            if (wr && a == 8'h14)
                msk <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_answer: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_unmapped: assert property (s_access |-> pslverr == !mapped)
        else $error("wrong pslverr");
    a_data_idle: assert property (!pready || pslverr |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_pin_value: assert property (
        pin_out == ($past(oe) ? $past(en) &
                    ($past(core_raw_result, 3) ^ $past(inv)) : $past(lat)))
        else $error("pin level wrong");
    a_pin_dir: assert property (dir == dir_q |-> pin_oe == !dir)
        else $error("pin enable wrong");
    a_power_en: assert property (en == en_q |-> core_power_on == en)
        else $error("power state wrong");
    a_speed_sel: assert property (spd == spd_q |-> core_speed_normal == spd)
        else $error("speed select wrong");
    a_irq_mask: assert property (!msk && !msk_q |-> !irq)
        else $error("irq while masked");
endmodule
bind comparator_output_control comparator_output_control_props i_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_raw_result, .core_power_on,
    .core_speed_normal, .pin_out, .pin_oe, .irq);
`default_nettype wire

// ---- analog_core_model.sv ----
// Behavioural analog comparator core
`default_nettype none
module analog_core_model (
    input  wire logic power_on,
    input  wire logic speed_normal,
    input  var  int   vn,
    input  var  int   vp,
    output var  logic raw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cmp;
    logic junk = 1'b0;
    // A powered-down core gives no valid level, so it wanders
    always #3 junk = ~junk;
    always @* cmp = power_on ? (vn < vp) : junk;
    // Low-power mode answers later
    always @(cmp) raw <= #(speed_normal ? 3 : 9) cmp;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the comparator output control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, raw, pin_out, pin_oe, irq, pon, spn;
    logic        pready, pslverr, e;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    int          vn = 0, vp = 0, error_cnt = 0, checks = 0, cyc = 0;
    bit          en, oe, inv, spd, lat, dir, res;
    logic [31:0] rv [6] = '{32'h4, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    comparator_output_control #(.INSTR_DIV(2)) i_comparator_output_control (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .core_raw_result(raw), .core_power_on(pon),
        .core_speed_normal(spn), .pin_out, .pin_oe, .irq);
    analog_core_model i_analog_core_model (.power_on(pon),
        .speed_normal(spn), .vn, .vp, .raw);
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 5000) begin
        error_cnt++;
        conclude();
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // Called right after a rising edge; waits for pready, no fixed latency
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] cf(bit r);
        return {24'h0, en, r, oe, inv, 1'b0, spd, 2'h0};
    endfunction
    initial begin
        void'($urandom(84));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rv[i]) begin
            apb(0, 8'(4 * i), 0);
            chk(rd, rv[i]);
        end
        apb(0, 8'h20, 0);
        chk(rd, 0);
        chk_bit(e, 1);
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            {en, oe, inv, spd, lat, dir} = 6'($urandom);
            vn = $urandom_range(100);
            vp = vn + ($urandom_range(1) ? 7 : -7);
            apb(1, 8'h00, cf(0));
            apb(1, 8'h0C, {30'h0, lat, dir});
            repeat (12) @(posedge pclk);
            res = en & ((vn < vp) ^ inv);
            apb(0, 8'h00, 0);
            chk(rd, cf(res));
            apb(0, 8'h08, 0);
            chk(rd, {31'h0, res});
            chk_bit(pin_out, oe ? res : lat);
            chk_bit(pin_oe, !dir);
            chk_bit(pon, en);
            chk_bit(spn, spd);
        end
        $display("test result and pin done");
        {en, oe, inv, spd} = 4'hB;
        apb(1, 8'h00, cf(0));
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h04, k[0] ? 32'h80 : 32'h40);
            apb(1, 8'h14, {31'h0, k[1]});
            vn = 50;
            vp = k[0] ? 90 : 10;
            repeat (12) @(posedge pclk);
            apb(0, 8'h10, 0);
            vp = k[0] ? 10 : 90;
            repeat (12) @(posedge pclk);
            chk_bit(irq, k[1]);
            apb(0, 8'h10, 0);
            chk(rd, 1);
            apb(0, 8'h10, 0);
            chk(rd, 0);
            chk_bit(irq, 0);
        end
        $display("test interrupt done");
        conclude();
    end
endmodule
`default_nettype wire
